// ### rtl/frame_hdr_pkg.sv
// Constants shared by the point cloud header framer and its checksum unit
package frame_hdr_pkg;
    localparam int HDR_BYTES = 42;
    localparam int MARK_BYTES = 2;
    localparam int AZ_BYTES = 2;
    localparam int CHAN_ENTRY_BYTES = 3;
    localparam int UDP_HDR_BYTES = 8;
    localparam int IP_HDR_BYTES = 20;
    localparam int ADD_LEN_OFF = 22;
    localparam int ADD_LEN_ON = 26;
    localparam int DEF_BLOCKS = 10;
    localparam int DEF_CHANNELS = 40;
    localparam logic [31:0] DEF_SRC_IP = 32'hc0a801c9;
    localparam logic [31:0] BCAST_IP = 32'hffffffff;
    localparam logic [47:0] BCAST_MAC = 48'hffffffffffff;
    localparam logic [15:0] ETHERTYPE_IPV4 = 16'h0800;
    localparam logic [7:0] IP_VER_IHL = 8'h45;
    localparam logic [7:0] IP_DSCP_ECN = 8'h00;
    localparam logic [15:0] IP_FLAGS_FRAG = 16'h4000;
    localparam logic [7:0] IP_TTL = 8'h40;
    localparam logic [7:0] IP_PROTO_UDP = 8'h11;
    localparam logic [15:0] UDP_SRC_PORT = 16'h2710;
    localparam logic [15:0] UDP_DST_PORT = 16'h0940;
    localparam logic [15:0] UDP_CSUM_NONE = 16'h0000;
    localparam logic [15:0] BLOCK_MARKER = 16'hffee;
    localparam logic [15:0] IP_ID_RESET = 16'h0000;
    localparam logic SEQ_RESET = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_MARK = 3'b011,
        ST_AZ = 3'b010,
        ST_CHAN = 3'b110,
        ST_ADD = 3'b111
    } frame_state_t;
endpackage : frame_hdr_pkg

// ### rtl/ip_header_checksum.sv
// Ones-complement IPv4 header checksum over the fixed framer header
`timescale 1ns/100ps
module ip_header_checksum
    import frame_hdr_pkg::*;
(
    input wire logic [31:0] src_ip_in,
    input wire logic [15:0] total_len_in,
    input wire logic [15:0] ident_in,
    output logic [15:0] csum_out
);
    logic [19:0] sum;
    logic [16:0] fold1;
    logic [15:0] fold2;

    always_comb
    begin
        sum = 20'({IP_VER_IHL, IP_DSCP_ECN}) + 20'(total_len_in) + 20'(ident_in)
            + 20'(IP_FLAGS_FRAG) + 20'({IP_TTL, IP_PROTO_UDP})
            + 20'(src_ip_in[31:16]) + 20'(src_ip_in[15:0])
            + 20'(BCAST_IP[31:16]) + 20'(BCAST_IP[15:0]);
        fold1 = 17'(sum[15:0]) + 17'(sum[19:16]);
        fold2 = fold1[15:0] + 16'(fold1[16]);
        csum_out = ~fold2;
    end
endmodule : ip_header_checksum

// ### rtl/point_cloud_udp_header_framer.sv
// Point cloud packet framer: Ethernet/IPv4/UDP header, block markers, payload
//
// Function
// (RQ1) Emit UDP/IPv4 packets toward 100 Mbps MAC
// (RQ2) Start framing automatically once link is up
// (RQ3) Header is 42 bytes in fixed order
// (RQ4) Broadcast destination MAC, own source MAC
// (RQ5) Unit MAC used as source everywhere
// (RQ6) Frame type bytes 0x08 then 0x00
// (RQ7) Source IP default, broadcast destination IP
// (RQ8) Version 4, 20-byte header, DSCP zero
// (RQ9) Don't fragment, TTL 64, protocol 17
// (RQ10) Total length 1290 or 1294 by sequence, correct header checksum
// (RQ11) UDP ports 10000 source, 2368 destination
// (RQ12) UDP length 1270 or 1274 by sequence
// (RQ13) Sequence off at reset, trailer 22/26
// (RQ14) Payload multi-byte values sent LSB first
// (RQ15) Ten blocks each begin with marker 0xFFEE
// (RQ16) Block: marker, azimuth, 40 channel entries
// (RQ17) UDP checksum sent as zero
`timescale 1ns/100ps
module point_cloud_udp_header_framer
    import frame_hdr_pkg::*;
#(
    parameter int BLOCKS = DEF_BLOCKS,
    parameter int CHANNELS = DEF_CHANNELS,
    parameter logic [31:0] SRC_IP = DEF_SRC_IP
)
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic link_up_in,
    input wire logic seq_enable_in,
    input wire logic [47:0] mac_addr_in,
    input wire logic [15:0] azimuth_in,
    input wire logic [7:0] pay_data_in,
    input wire logic pay_valid_in,
    output logic pay_ready_out,
    output logic azimuth_take_out,
    input wire logic tx_next_in,
    output logic [7:0] tx_data_out,
    output logic tx_valid_out,
    output logic tx_first_out,
    output logic tx_last_out
);
    import frame_hdr_pkg::*;

    localparam int CHAN_BYTES = CHAN_ENTRY_BYTES * CHANNELS;
    localparam int BLOCK_BYTES = MARK_BYTES + AZ_BYTES + CHAN_BYTES;
    localparam int UDP_LEN_OFF = UDP_HDR_BYTES + BLOCKS * BLOCK_BYTES + ADD_LEN_OFF;
    localparam int UDP_LEN_ON = UDP_HDR_BYTES + BLOCKS * BLOCK_BYTES + ADD_LEN_ON;
    localparam int FRAME_LEN_OFF = HDR_BYTES + UDP_LEN_OFF - UDP_HDR_BYTES;
    localparam int FRAME_LEN_ON = HDR_BYTES + UDP_LEN_ON - UDP_HDR_BYTES;

    generate
        if (BLOCKS < 1 || BLOCKS > 255 || CHANNELS < 1 || CHAN_BYTES > 255
            || UDP_LEN_ON + IP_HDR_BYTES > 65535 || FRAME_LEN_ON > 4095)
        begin : g_bad_params
            $error("framer parameters out of range");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Link detect
    // ----------------------------------------------------------------
    logic link_s1;
    logic link_s2;
    logic link_s3;
    logic link_ok;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            link_s3 <= 1'b0;
            link_ok <= 1'b0;
        end
        else
        begin
            link_s1 <= link_up_in;
            link_s2 <= link_s1;
            link_s3 <= link_s2;
            if (link_s2 == link_s3)
                link_ok <= link_s3;
        end
    end

    // ----------------------------------------------------------------
    // Framing state
    // ----------------------------------------------------------------
    frame_state_t state;
    logic [7:0] cnt;
    logic [7:0] blk;
    logic seq_on;
    logic [15:0] ident;
    logic [335:0] hdr_vec;
    logic [15:0] az_reg;
    logic pend;
    logic hold_full;
    logic [7:0] hold_data;
    logic emit;
    logic take;
    logic next_hold_full;
    logic [7:0] cur_byte;
    logic [7:0] add_len;
    logic [15:0] udp_len;
    logic [15:0] ip_len;
    logic [15:0] csum;

    assign add_len = seq_on ? 8'(ADD_LEN_ON) : 8'(ADD_LEN_OFF);
    // UDP and IP lengths follow the live seq_enable_in input, latched into the header at frame start
    assign udp_len = seq_enable_in ? 16'(UDP_LEN_ON) : 16'(UDP_LEN_OFF); // see (RQ12)
    assign ip_len = udp_len + 16'(IP_HDR_BYTES); // see (RQ10)
    assign take = pay_valid_in && pay_ready_out;
    assign emit = pend && (state == ST_HDR || state == ST_MARK || state == ST_AZ
        || ((state == ST_CHAN || state == ST_ADD) && hold_full));
    assign next_hold_full = (hold_full && !(emit && (state == ST_CHAN || state == ST_ADD)))
        || take;

    ip_header_checksum u_csum (
        .src_ip_in(SRC_IP),
        .total_len_in(ip_len),
        .ident_in(ident),
        .csum_out(csum)
    );

    always_comb
    begin
        case (state)
            ST_HDR: cur_byte = hdr_vec[335:328];
            ST_MARK: cur_byte = (cnt == 8'h00) ? BLOCK_MARKER[15:8] : BLOCK_MARKER[7:0]; // see (RQ15)
            ST_AZ: cur_byte = (cnt == 8'h00) ? az_reg[7:0] : az_reg[15:8]; // see (RQ14)
            ST_CHAN: cur_byte = hold_data;
            ST_ADD: cur_byte = hold_data;
            default: cur_byte = 8'h00;
        endcase
    end

    // One byte request from the MAC is remembered while waiting; further requests before it is served merge with it
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
            pend <= 1'b0;
        else if (tx_next_in)
            pend <= 1'b1;
        else if (emit)
            pend <= 1'b0;
    end

    // One-byte holding stage decouples the payload source from MAC pacing
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            hold_full <= 1'b0;
            hold_data <= 8'h00;
            pay_ready_out <= 1'b0;
        end
        else
        begin
            hold_full <= next_hold_full;
            pay_ready_out <= !next_hold_full;
            if (take)
                hold_data <= pay_data_in;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            state <= ST_IDLE;
            cnt <= 8'h00;
            blk <= 8'h00;
            seq_on <= SEQ_RESET; // see (RQ13)
            ident <= IP_ID_RESET;
            hdr_vec <= '0;
            az_reg <= 16'h0000;
            azimuth_take_out <= 1'b0;
        end
        else
        begin
            azimuth_take_out <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (link_ok) // see (RQ2)
                    begin
                        seq_on <= seq_enable_in;
                        ident <= ident + 16'h0001;
                        cnt <= 8'h00;
                        blk <= 8'h00;
                        state <= ST_HDR;
                        hdr_vec <= {BCAST_MAC, mac_addr_in, ETHERTYPE_IPV4, // see (RQ4) (RQ5) (RQ6)
                            IP_VER_IHL, IP_DSCP_ECN, ip_len, ident, // see (RQ8) (RQ10)
                            IP_FLAGS_FRAG, IP_TTL, IP_PROTO_UDP, csum, // see (RQ9) (RQ10)
                            SRC_IP, BCAST_IP, UDP_SRC_PORT, UDP_DST_PORT, // see (RQ7) (RQ11)
                            udp_len, UDP_CSUM_NONE}; // see (RQ3) (RQ17)
                    end
                end
                ST_HDR:
                begin
                    if (emit)
                    begin
                        hdr_vec <= hdr_vec << 8;
                        cnt <= cnt + 8'h01;
                        if (cnt == 8'(HDR_BYTES - 1))
                        begin
                            cnt <= 8'h00;
                            state <= ST_MARK;
                        end
                    end
                end
                ST_MARK:
                begin
                    if (emit)
                    begin
                        cnt <= cnt + 8'h01;
                        if (cnt == 8'(MARK_BYTES - 1))
                        begin
                            az_reg <= azimuth_in;
                            azimuth_take_out <= 1'b1;
                            cnt <= 8'h00;
                            state <= ST_AZ;
                        end
                    end
                end
                ST_AZ:
                begin
                    if (emit)
                    begin
                        cnt <= cnt + 8'h01;
                        if (cnt == 8'(AZ_BYTES - 1))
                        begin
                            cnt <= 8'h00;
                            state <= ST_CHAN;
                        end
                    end
                end
                ST_CHAN:
                begin
                    if (emit)
                    begin
                        cnt <= cnt + 8'h01;
                        if (cnt == 8'(CHAN_BYTES - 1)) // see (RQ16)
                        begin
                            cnt <= 8'h00;
                            blk <= blk + 8'h01;
                            state <= (blk == 8'(BLOCKS - 1)) ? ST_ADD : ST_MARK; // see (RQ15)
                        end
                    end
                end
                ST_ADD:
                begin
                    if (emit)
                    begin
                        cnt <= cnt + 8'h01;
                        if (cnt == add_len - 8'h01) // see (RQ13)
                            state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Byte output toward the MAC
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            tx_valid_out <= 1'b0;
            tx_data_out <= 8'h00;
            tx_first_out <= 1'b0;
            tx_last_out <= 1'b0;
        end
        else
        begin
            tx_valid_out <= emit; // see (RQ1)
            tx_first_out <= emit && state == ST_HDR && cnt == 8'h00;
            tx_last_out <= emit && state == ST_ADD && cnt == add_len - 8'h01;
            if (emit)
                tx_data_out <= cur_byte;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [11:0] idx;
    logic seq_seen;

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            idx <= 12'h000;
            seq_seen <= SEQ_RESET;
        end
        else if (tx_valid_out)
        begin
            idx <= tx_last_out ? 12'h000 : idx + 12'h001;
            if (tx_first_out)
                seq_seen <= seq_on;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Following byte picked out by its index; host pacing gaps up to 40 cycles
    sequence marker_seq;
        tx_valid_out && tx_data_out == 8'hff
            ##[1:41] tx_valid_out && idx == 12'h02b && tx_data_out == 8'hee;
    endsequence

    sequence ttl_proto_seq;
        tx_data_out == 8'h40
            ##[1:41] tx_valid_out && idx == 12'h017 && tx_data_out == 8'h11;
    endsequence

    dst_mac_a: assert property (tx_valid_out && idx < 12'h006 |-> tx_data_out == 8'hff) // see (RQ4)
        else $error("destination MAC byte not broadcast");
    ethertype_a: assert property (tx_valid_out && idx == 12'h00c |-> tx_data_out == 8'h08) // see (RQ6)
        else $error("frame type high byte wrong");
    ip_version_a: assert property (tx_valid_out && idx == 12'h00e |-> tx_data_out == 8'h45) // see (RQ8)
        else $error("IPv4 version or header length wrong");
    ttl_proto_a: assert property (tx_valid_out && idx == 12'h016 |-> ttl_proto_seq) // see (RQ9)
        else $error("TTL or protocol byte wrong");
    dst_port_a: assert property (tx_valid_out && idx == 12'h024 |-> tx_data_out == 8'h09) // see (RQ11)
        else $error("UDP destination port wrong");
    udp_len_a: assert property (tx_valid_out && idx == 12'h027
        |-> tx_data_out == (seq_seen ? 8'hfa : 8'hf6)) // see (RQ12)
        else $error("UDP length low byte wrong");
    udp_csum_a: assert property (tx_valid_out && idx == 12'h029 |-> tx_data_out == 8'h00) // see (RQ17)
        else $error("UDP checksum not zero");
    block_marker_a: assert property (tx_valid_out && idx == 12'h02a |-> marker_seq) // see (RQ15)
        else $error("block marker missing after header");
    frame_len_a: assert property (tx_last_out
        |-> idx == (seq_seen ? 12'(FRAME_LEN_ON - 1) : 12'(FRAME_LEN_OFF - 1))) // see (RQ3)
        else $error("frame byte count wrong");
    ip_len_a: assert property (tx_valid_out && idx == 12'h011
        |-> tx_data_out == (seq_seen ? 8'h0e : 8'h0a)) // see (RQ10)
        else $error("IPv4 total length low byte wrong");
endmodule : point_cloud_udp_header_framer

// ### dv/host_rx_model.sv
// Host side model: asks the framer for bytes and captures whole frames
`timescale 1ns/100ps
module host_rx_model
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic stall_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    input wire logic tx_first_in,
    input wire logic tx_last_in,
    output logic tx_next_out
);
    logic [7:0] rx_buf [0:2047];
    int rx_idx = 0;
    int rx_len = 0;
    int rx_count = 0;
    int frames = 0;
    int seen;

    // ----
    // Requests
    // ----
    initial
    begin
        tx_next_out = 1'b0;
        forever
        begin
            @(negedge ref_clk_in);
            if (!rst_in && !stall_in)
            begin
                seen = rx_count;
                tx_next_out = 1'b1;
                @(negedge ref_clk_in);
                tx_next_out = 1'b0;
                // One request outstanding until its byte arrives
                while (rx_count == seen)
                    @(negedge ref_clk_in);
            end
        end
    end

    // ----
    // Capture
    // ----
    always @(posedge ref_clk_in)
    begin
        if (tx_valid_in)
        begin
            if (tx_first_in)
                rx_idx = 0;
            rx_buf[rx_idx] = tx_data_in;
            rx_idx++;
            rx_count++;
            if (tx_last_in)
            begin
                rx_len = rx_idx;
                frames++;
            end
        end
    end
endmodule : host_rx_model

// ### dv/test_point_cloud_udp_header_framer.sv
// Self-checking bench for the point cloud header framer
`timescale 1ns/100ps
module test_point_cloud_udp_header_framer;
    import frame_hdr_pkg::*;
`define CHK(name, e, g) begin tests_run++; if ((e) !== (g)) begin fail_count++; \
    $display("Error %s expected %h seen %h", name, e, g); end end
`define RX(i) host_rx_model_inst.rx_buf[i]

    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic link_up_in = 1'b0;
    logic seq_enable_in = 1'b0;
    logic [47:0] mac_addr_in = 48'h02a1b2c3d4e5;
    logic [15:0] azimuth_in = 16'h1234;
    logic [7:0] pay_data_in = 8'h00;
    logic pay_valid_in = 1'b0;
    logic stall = 1'b0;
    logic take_pend = 1'b0;
    logic pay_ready_out, azimuth_take_out, tx_next_in;
    logic tx_valid_out, tx_first_out, tx_last_out;
    logic [7:0] tx_data_out;
    int seed = 28;
    int fail_count = 0;
    int tests_run = 0;
    logic [7:0] pay_q [$];
    logic [15:0] az_q [$];

    point_cloud_udp_header_framer point_cloud_udp_header_framer_inst (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .link_up_in(link_up_in),
        .seq_enable_in(seq_enable_in), .mac_addr_in(mac_addr_in), .azimuth_in(azimuth_in),
        .pay_data_in(pay_data_in), .pay_valid_in(pay_valid_in), .pay_ready_out(pay_ready_out),
        .azimuth_take_out(azimuth_take_out), .tx_next_in(tx_next_in),
        .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
        .tx_first_out(tx_first_out), .tx_last_out(tx_last_out));

    host_rx_model host_rx_model_inst (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .stall_in(stall),
        .tx_data_in(tx_data_out), .tx_valid_in(tx_valid_out), .tx_first_in(tx_first_out),
        .tx_last_in(tx_last_out), .tx_next_out(tx_next_in));

    initial
        forever #25 ref_clk_in = ~ref_clk_in;

    // ----
    // Payload and azimuth sources
    // ----
    always @(negedge ref_clk_in)
    begin
        stall <= ($random(seed) & 3) == 0;
        if (take_pend)
            pay_q.push_back(pay_data_in);
        // Byte held steady until taken
        if (take_pend || !pay_valid_in)
        begin
            pay_valid_in = ($random(seed) & 7) != 0;
            pay_data_in = 8'($random(seed));
        end
        take_pend = pay_valid_in && pay_ready_out;
        if (azimuth_take_out)
        begin
            az_q.push_back(azimuth_in);
            azimuth_in = 16'($random(seed));
        end
    end

    // ----
    // Expectations
    // ----
    function automatic logic [15:0] ip_sum(input logic [15:0] tot, input logic [15:0] id);
        logic [31:0] s;
        s = 32'h4500 + tot + id + 32'h4000 + 32'h4011 + 32'hc0a8 + 32'h01c9 + 32'h1fffe;
        s = s[15:0] + s[31:16];
        s = s[15:0] + s[31:16];
        return ~s[15:0];
    endfunction : ip_sum

    function automatic logic [335:0] hdr(input logic seq, input logic [47:0] mac,
        input logic [15:0] id);
        logic [15:0] tot;
        tot = seq ? 16'h050e : 16'h050a;
        return {48'hffffffffffff, mac, 16'h0800, 16'h4500, tot, id, 16'h4000, 16'h4011,
            ip_sum(tot, id), 32'hc0a801c9, 32'hffffffff, 16'h2710, 16'h0940,
            seq ? 16'h04fa : 16'h04f6, 16'h0000};
    endfunction : hdr

    task automatic check_frame(input logic seq, input logic [47:0] mac, input logic [15:0] id);
        logic [335:0] h;
        logic [15:0] az;
        logic [7:0] d;
        int p;
        h = hdr(seq, mac, id);
        `CHK("frame_len", 1304 + 4 * seq, host_rx_model_inst.rx_len)
        for (int i = 0; i < 42; i++)
            `CHK("hdr_byte", h[335 - 8 * i -: 8], `RX(i))
        p = 42;
        for (int b = 0; b < 10; b++)
        begin
            az = az_q.pop_front();
            `CHK("marker_hi", 8'hff, `RX(p))
            `CHK("marker_lo", 8'hee, `RX(p + 1))
            `CHK("az_lo", az[7:0], `RX(p + 2))
            `CHK("az_hi", az[15:8], `RX(p + 3))
            for (int k = 4; k < 124; k++)
            begin
                d = pay_q.pop_front();
                `CHK("chan_byte", d, `RX(p + k))
            end
            p += 124;
        end
        for (int k = 0; k < 22 + 4 * seq; k++)
        begin
            d = pay_q.pop_front();
            `CHK("trailer_byte", d, `RX(p + k))
        end
    endtask : check_frame

    // Settings for the next frame change mid-frame
    task automatic run_frame(input logic nseq, input logic nlink);
        logic s;
        logic [47:0] m;
        int f;
        int c;
        int n;
        f = host_rx_model_inst.frames;
        c = host_rx_model_inst.rx_count;
        s = seq_enable_in;
        m = mac_addr_in;
        n = 0;
        while (host_rx_model_inst.rx_count < c + 300 && n < 20000)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        seq_enable_in = nseq;
        mac_addr_in = {16'($random(seed)), 32'($random(seed))};
        link_up_in = nlink;
        while (host_rx_model_inst.frames == f && n < 20000)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        `CHK("frame_done", 1'b1, n < 20000)
        check_frame(s, m, 16'(f));
    endtask : run_frame

    task summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (16) @(negedge ref_clk_in);
        `CHK("valid_in_reset", 1'b0, tx_valid_out)
        rst_in = 1'b0;
        link_up_in = 1'b1;
        run_frame(1'b1, 1'b1);
        run_frame(1'b0, 1'b0);
        repeat (3000) @(negedge ref_clk_in);
        `CHK("frames_link_down", 2, host_rx_model_inst.frames)
        link_up_in = 1'b1;
        run_frame(1'b0, 1'b1);
        summarize();
    end

    initial
    begin
        repeat (60000) @(posedge ref_clk_in);
        fail_count++;
        summarize();
    end
endmodule : test_point_cloud_udp_header_framer
